// [verilog/eewr_defines.svh]
// timing counts, address fields and bus codes of the two-wire eeprom write slave
`ifndef EEWR_DEFINES_SVH
`define EEWR_DEFINES_SVH
`define EEWR_CLK_PERIOD_NS 100
`define EEWR_T_PROG_NS     5000000
`define EEWR_PROG_CYCLES   (`EEWR_T_PROG_NS / `EEWR_CLK_PERIOD_NS)
`define EEWR_DEV_CODE      4'ha
`define EEWR_ADDR_W        13
`define EEWR_ADDR_HI_W     5
`define EEWR_PAGE_W        5
`define EEWR_PAGE_BYTES    32
`define EEWR_MEM_BYTES     8192
`define EEWR_BYTE_BITS     4'h8
`define EEWR_DATA_BYTE_NO  2'h3
`define EEWR_SYNC_W        6
`endif

// [verilog/eewr_pkg.sv]
// types shared by the two-wire eeprom write slave
package eewr_pkg;
	// bus phase of the slave
	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'b00,
		ST_RECV   = 2'b01,
		ST_ACK    = 2'b10,
		ST_IGNORE = 2'b11
	} eewr_state_t;
endpackage : eewr_pkg

// [verilog/eewr_sync.sv]
// two-flop synchronisers for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module eewr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d_in,
	output var  logic [W-1:0] q_out
);
	logic [W-1:0] meta_q; // first stage, read only by the second

	// one pair of flops per pin
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk_sys)
			begin
				if (!rstn)
				begin
					meta_q[i] <= 1'b0;
					q_out[i]  <= 1'b0;
				end
				else
				begin
					meta_q[i] <= d_in[i];
					q_out[i]  <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule : eewr_sync
`default_nettype wire

// [verilog/eewr_array.sv]
// page buffer, self-timed programming and storage array
`timescale 1ns/1ps
`default_nettype none
`include "eewr_defines.svh"
module eewr_array #(
	parameter int PROG_CYCLES = `EEWR_PROG_CYCLES,
	parameter bit BIG_VARIANT = 1'b1
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	input  wire logic                    buf_we,
	input  wire logic                    buf_clr,
	input  wire logic [`EEWR_PAGE_W-1:0] buf_idx,
	input  wire logic [7:0]              buf_wdata,
	input  wire logic                    prog_go,
	input  wire logic [`EEWR_ADDR_W-1:0] prog_addr,
	input  wire logic [`EEWR_ADDR_W-1:0] rd_addr,
	output var  logic                    busy,
	output var  logic [7:0]              rd_data
);
	import eewr_pkg::*;
	logic [7:0]  mem [0:`EEWR_MEM_BYTES-1];   // storage array
	logic [7:0]  pbuf_q [0:`EEWR_PAGE_BYTES-1]; // page buffer bytes
	logic [`EEWR_PAGE_BYTES-1:0] pval_q;     // buffered byte valid
	logic [31:0] cnt_q;                      // programming time left
	logic [`EEWR_ADDR_W-1:0] base_q;         // page being programmed
	logic [`EEWR_ADDR_W-1:0] rd_eff;         // variant-wrapped read address
	logic        done;

	// small variant has no top address bit, so addresses wrap at 4096
	assign rd_eff = BIG_VARIANT ? rd_addr : {1'b0, rd_addr[`EEWR_ADDR_W-2:0]};
	assign done   = busy && (cnt_q == 32'h0000_0000);

	// per-entry page buffer; a later byte to the same slot replaces it
	genvar i;
	generate
		for (i = 0; i < `EEWR_PAGE_BYTES; i++)
		begin : g_ent
			always_ff @(posedge clk_sys)
			begin
				if (!rstn || buf_clr || done)
					pval_q[i] <= 1'b0;
				else if (buf_we && (int'(buf_idx) == i))
				begin
					pval_q[i] <= 1'b1;
					pbuf_q[i] <= buf_wdata;
				end
			end
		end
	endgenerate

	// self-timed cycle, clears by itself
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			busy  <= 1'b0;
			cnt_q <= 32'h0000_0000;
		end
		else if (prog_go && !busy)
		begin
			busy  <= 1'b1;
			cnt_q <= PROG_CYCLES - 1;
		end
		else if (done)
			busy  <= 1'b0;
		else if (busy)
			cnt_q <= cnt_q - 32'h0000_0001;
	end

	// page address held for the whole cycle
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			base_q <= '0;
		else if (prog_go && !busy)
			base_q <= BIG_VARIANT ? prog_addr : {1'b0, prog_addr[`EEWR_ADDR_W-2:0]};
	end

	// buffered bytes of the page land in one step at the end of the cycle
	always_ff @(posedge clk_sys)
	begin
		if (done)
			for (int k = 0; k < `EEWR_PAGE_BYTES; k++)
				if (pval_q[k])
					mem[{base_q[`EEWR_ADDR_W-1:`EEWR_PAGE_W], k[`EEWR_PAGE_W-1:0]}] <= pbuf_q[k];
		rd_data <= mem[rd_eff];
	end
endmodule : eewr_array
`default_nettype wire

// [verilog/eewr_slave.sv]
// two-wire eeprom slave: start/stop, addressing, byte and page writes
// Operation
// - floating straps read as zero (no pull-down here; strap pins go straight to the synchronisers)
// - write protect high blocks all programming
// - nothing happens before a start
// - stop is sda rising while scl high
// - sda change during scl high is control
// - one scl pulse per bit, sampled high
// - receiver pulls sda low on ninth pulse
// - upper address nibble must be 1010
// - next three bits match the straps
// - address lsb one reads, zero writes
// - acknowledge only a full address match
// - byte write: address, two words, data, stop
// - stop starts programming; deaf until done
// - up to 32 bytes per page write
// - only low five address bits increment
// - overflow wraps and overwrites buffered bytes
// - whole page programmed in one cycle
// - polling gets no ack while busy
// - programming self-timed, about five milliseconds
// - array holds 4096 or 8192 bytes
// - address counter holds last location plus one
`timescale 1ns/1ps
`default_nettype none
`include "eewr_defines.svh"
module eewr_slave #(
	parameter int PROG_CYCLES = `EEWR_PROG_CYCLES,
	parameter bit BIG_VARIANT = 1'b1
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	input  wire logic                    scl,
	input  wire logic                    sda_in,
	output var  logic                    sda_out,
	output var  logic                    sda_oe,
	input  wire logic                    strap_bit_zero,
	input  wire logic                    strap_bit_one,
	input  wire logic                    strap_bit_two,
	input  wire logic                    write_protect,
	output var  logic [`EEWR_ADDR_W-1:0] read_addr,
	output var  logic [7:0]              read_data,
	output var  logic                    prog_busy
);
	import eewr_pkg::*;

	logic [`EEWR_SYNC_W-1:0] pins_s;     // synchronised pins
	logic        scl_s;                  // clean scl
	logic        sda_s;                  // clean sda
	logic [2:0]  strap_s;                // clean straps
	logic        wp_s;                   // clean write protect
	logic        scl_p_q;                // scl one sample back
	logic        sda_p_q;                // sda one sample back
	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;               // start seen
	logic        stop_ev;                // stop seen
	eewr_state_t st_q;                   // bus phase
	logic [3:0]  bit_cnt_q;              // bits of current byte
	logic [1:0]  byte_no_q;              // 0 dev, 1 hi, 2 lo, 3 data
	logic [7:0]  sh_q;                   // receive shifter
	logic        byte_end;               // eighth bit done, scl falling
	logic        dev_match;              // address byte is ours
	logic        ack_now;                // acknowledge this byte
	logic        is_read_q;              // addressed for read
	logic [`EEWR_ADDR_W-1:0] addr_q;     // word address counter
	logic        pending_q;              // data bytes buffered
	logic        prog_go_q;              // start programming pulse
	logic        buf_we;                 // store data byte
	logic        buf_clr;                // drop stale page data
	logic [31:0] busy_len_q;             // cycles spent programming so far

	// pins arrive from the bus, outside our clock
	eewr_sync #(
		.W(`EEWR_SYNC_W)
	) u_sync (
		.clk_sys(clk_sys),
		.rstn   (rstn),
		.d_in   ({write_protect, strap_bit_two, strap_bit_one, strap_bit_zero, sda_in, scl}),
		.q_out  (pins_s)
	);

	assign scl_s   = pins_s[0];
	assign sda_s   = pins_s[1];
	assign strap_s = pins_s[4:2];
	assign wp_s    = pins_s[5];

	// edge history of the clean bus lines
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// sda moving while scl stays high is framing, never data
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_ev  = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign byte_end = (st_q == ST_RECV) && scl_fall && (bit_cnt_q == `EEWR_BYTE_BITS);

	// address decode; busy makes the device deaf to polls
	assign dev_match = (sh_q[7:4] == `EEWR_DEV_CODE)
		&& (sh_q[3:1] == strap_s);
	always_comb
	begin
		if (byte_no_q == 2'h0)
			ack_now = dev_match && !prog_busy;
		else
			ack_now = 1'b1;
	end

	// phase machine
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			st_q <= ST_IDLE;
		else if (start_ev)
			st_q <= ST_RECV;
		else if (stop_ev)
			st_q <= ST_IDLE;
		else
			case (st_q)
				ST_RECV:
					if (byte_end)
						st_q <= ack_now ? ST_ACK : ST_IGNORE;
				ST_ACK:
					if (scl_fall)
						st_q <= is_read_q ? ST_IGNORE : ST_RECV;
				default:
					st_q <= st_q;
			endcase
	end

	// one bit per scl pulse, taken on the rising edge
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			bit_cnt_q <= 4'h0;
			sh_q      <= 8'h00;
		end
		else if (start_ev || ((st_q == ST_ACK) && scl_fall))
			bit_cnt_q <= 4'h0;
		else if ((st_q == ST_RECV) && scl_rise && (bit_cnt_q != `EEWR_BYTE_BITS))
		begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			sh_q      <= {sh_q[6:0], sda_s};
		end
	end

	// byte position within the transfer; data bytes saturate
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || start_ev)
			byte_no_q <= 2'h0;
		else if ((st_q == ST_ACK) && scl_fall && (byte_no_q != `EEWR_DATA_BYTE_NO))
			byte_no_q <= byte_no_q + 2'h1;
	end

	// direction bit; reads are served elsewhere, we only ack them
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || start_ev)
			is_read_q <= 1'b0;
		else if (byte_end && (byte_no_q == 2'h0))
			is_read_q <= sh_q[0];
	end

	// open-drain ack: pull low across the ninth pulse only
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			sda_oe <= 1'b0;
		else if (start_ev || stop_ev)
			sda_oe <= 1'b0;
		else if (byte_end)
			sda_oe <= ack_now;
		else if ((st_q == ST_ACK) && scl_fall)
			sda_oe <= 1'b0;
	end

	// the pin only ever pulls low
	always_ff @(posedge clk_sys)
	begin
		sda_out <= 1'b0;
	end

	// word address; data bytes step only the low five bits
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			addr_q <= '0;
		else if (byte_end && (byte_no_q == 2'h1))
			addr_q[`EEWR_ADDR_W-1:8] <= sh_q[`EEWR_ADDR_HI_W-1:0];
		else if (byte_end && (byte_no_q == 2'h2))
			addr_q[7:0] <= sh_q;
		else if (buf_we)
			addr_q[`EEWR_PAGE_W-1:0] <= addr_q[`EEWR_PAGE_W-1:0] + 5'h01;
	end

	// counter is last written plus one, seen by the read logic
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			read_addr <= '0;
		else
			read_addr <= addr_q;
	end

	assign buf_we  = byte_end && (byte_no_q == `EEWR_DATA_BYTE_NO) && !is_read_q;
	// a poll during programming must not wipe the page being written
	assign buf_clr = start_ev && !prog_busy;

	// data waiting for a stop
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || start_ev || stop_ev)
			pending_q <= 1'b0;
		else if (buf_we)
			pending_q <= 1'b1;
	end

	// stop ends the write; protection still acks but programs nothing
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			prog_go_q <= 1'b0;
		else
			prog_go_q <= stop_ev && pending_q && !wp_s && !prog_busy;
	end

	// buffer, timer and storage
	eewr_array #(
		.PROG_CYCLES(PROG_CYCLES),
		.BIG_VARIANT(BIG_VARIANT)
	) u_array (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.buf_we   (buf_we),
		.buf_clr  (buf_clr),
		.buf_idx  (addr_q[`EEWR_PAGE_W-1:0]),
		.buf_wdata(sh_q),
		.prog_go  (prog_go_q),
		.prog_addr(addr_q),
		.rd_addr  (read_addr),
		.busy     (prog_busy),
		.rd_data  (read_data)
	);

	// nothing moves before a start
	chk_idle_waits_start: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_q == ST_IDLE) && !start_ev |=> (st_q == ST_IDLE))
		else $error("left idle without a start");

	// ack drive starts only while scl is low
	chk_ack_scl_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(sda_oe) |-> !scl_s)
		else $error("ack asserted while scl high");

	// ack lasts until the ninth pulse ends
	chk_ack_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_q == ST_ACK) && sda_oe && !scl_fall && !start_ev && !stop_ev |=> sda_oe)
		else $error("ack released early");

	// wrong family code never acked
	chk_code_reject: assert property (@(posedge clk_sys) disable iff (!rstn)
		byte_end && (byte_no_q == 2'h0) && (sh_q[7:4] != 4'ha) |=> !sda_oe)
		else $error("foreign code acked");

	// strap mismatch never acked
	chk_strap_reject: assert property (@(posedge clk_sys) disable iff (!rstn)
		byte_end && (byte_no_q == 2'h0) && (sh_q[3:1] != strap_s) |=> !sda_oe)
		else $error("strap mismatch acked");

	// matching address acked when idle
	chk_match_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
		byte_end && (byte_no_q == 2'h0) && dev_match && !prog_busy |=> sda_oe && (st_q == ST_ACK))
		else $error("matching address not acked");

	// polls unanswered while programming
	chk_busy_silent: assert property (@(posedge clk_sys) disable iff (!rstn)
		byte_end && (byte_no_q == 2'h0) && prog_busy |=> !sda_oe ##1 !sda_oe)
		else $error("acked while busy");

	// page number fixed across a data byte
	chk_page_fixed: assert property (@(posedge clk_sys) disable iff (!rstn)
		buf_we |=> (addr_q[12:5] == $past(addr_q[12:5]))
			&& (addr_q[4:0] == $past(addr_q[4:0]) + 5'h01))
		else $error("page bits moved");

	// stop after data starts programming unless protected
	chk_stop_programs: assert property (@(posedge clk_sys) disable iff (!rstn)
		stop_ev && pending_q && !wp_s && !prog_busy |=> prog_go_q ##1 prog_busy)
		else $error("stop did not start programming");

	// protected stop starts nothing
	chk_wp_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
		stop_ev && wp_s && !prog_busy |=> !prog_go_q ##1 !prog_busy)
		else $error("programming under protection");

	// length of the running programming cycle; a counter, since the
	// full self-timed cycle is far too long for a delay range
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || !prog_busy)
			busy_len_q <= 32'h0000_0000;
		else
			busy_len_q <= busy_len_q + 32'h0000_0001;
	end

	// programming clears by itself
	chk_busy_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
		prog_busy |-> (busy_len_q < 32'(PROG_CYCLES)))
		else $error("programming never ended");

	// programming lasts exactly the self-timed count
	chk_busy_length: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(prog_busy) |-> (busy_len_q == 32'(PROG_CYCLES)))
		else $error("programming cycle of wrong length");
endmodule : eewr_slave
`default_nettype wire

// [dv/eewr_master.sv]
// two-wire bus master model that clocks and frames the bus
`timescale 1ns/1ps
`default_nettype none
module eewr_master (
	output var  logic scl,
	output var  logic sda_rel,
	input  wire logic sda_wire
);
	localparam int Q = 200; // quarter of the 800 ns bus clock

	// bus idles released high under the pull-up
	initial
	begin
		scl     = 1'b1;
		sda_rel = 1'b1;
	end

	// start: sda falls while scl high; also serves as repeated start
	task automatic start_cond();
	begin
		sda_rel = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_rel = 1'b0;
		#(2*Q) scl = 1'b0;
		#Q;
	end
	endtask : start_cond

	// msb first, sda moves only while scl low, ack read on ninth pulse
	task automatic send_byte(input logic [7:0] b, output logic ack);
	begin
		for (int i = 7; i >= 0; i--)
		begin
			sda_rel = b[i];
			#Q scl = 1'b1;
			#(2*Q) scl = 1'b0;
			#Q;
		end
		sda_rel = 1'b1; // release so the slave can pull low
		#Q scl = 1'b1;
		#Q ack = !sda_wire;
		#Q scl = 1'b0;
		#Q;
	end
	endtask : send_byte

	// stop: sda rises while scl high, ends every frame
	task automatic stop_cond();
	begin
		sda_rel = 1'b0;
		#Q scl = 1'b1;
		#(2*Q) sda_rel = 1'b1;
		#(2*Q);
	end
	endtask : stop_cond
endmodule : eewr_master
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the two-wire eeprom write slave
`timescale 1ns/1ps
`default_nettype none
`include "eewr_defines.svh"
module tb;
	localparam int PROG  = 200;   // shortened programming time
	localparam int LIMIT = 20000; // cycle ceiling, about three times the run
	logic                    clk_sys, rstn, scl, sda_rel, sda_out, sda_oe, wp, prog_busy;
	logic [2:0]              strap;
	logic [`EEWR_ADDR_W-1:0] read_addr;
	logic [7:0]              read_data, dev, ack;
	wire logic               sda_wire;
	int                      bad_count, checked, cyc, busy_run, last_len;
	logic                    busy_prev;
	logic [7:0]              mem [0:`EEWR_MEM_BYTES-1]; // reference array contents
	logic [12:0]             a1, a2;

	// open-drain wire with pull-up
	assign sda_wire = sda_rel & (sda_oe ? sda_out : 1'b1);

	eewr_slave #(.PROG_CYCLES(PROG), .BIG_VARIANT(1'b1)) dut (
		.clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .strap_bit_zero(strap[0]),
		.strap_bit_one(strap[1]), .strap_bit_two(strap[2]), .write_protect(wp),
		.read_addr(read_addr), .read_data(read_data), .prog_busy(prog_busy)
	);
	eewr_master m (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));

	// system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// hang guard plus busy length measured at each fall
	always @(posedge clk_sys)
	begin
		cyc       <= cyc + 1;
		busy_prev <= prog_busy;
		busy_run  <= (prog_busy === 1'b1) ? busy_run + 1 : 0;
		if (busy_prev === 1'b1 && prog_busy === 1'b0)
			last_len <= busy_run;
		if (cyc == LIMIT)
		begin
			bad_count++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
	begin
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask : check

	// write frame of n random bytes; the model follows page wrap
	task automatic wr_frame(input logic [7:0] d, input logic [12:0] a, input int n,
		input logic exp_ack);
		logic       k;
		logic [7:0] b;
	begin
		m.start_cond();
		m.send_byte(d, k);
		check("addr ack", 16'(k), 16'(exp_ack));
		if (k === 1'b1)
		begin
			m.send_byte({3'h0, a[12:8]}, k);
			check("hi ack", 16'(k), 16'h1);
			m.send_byte(a[7:0], k);
			check("lo ack", 16'(k), 16'h1);
			for (int i = 0; i < n; i++)
			begin
				b = 8'($urandom);
				m.send_byte(b, k);
				check("data ack", 16'(k), 16'h1);
				if (wp === 1'b0)
					mem[{a[12:5], 5'(a[4:0] + i)}] = b;
			end
		end
		m.stop_cond();
		if (k === 1'b1)
			check("read_addr", 16'(read_addr), 16'({a[12:5], 5'(a[4:0] + n)}));
	end
	endtask : wr_frame

	// address-only frame then compare the array byte
	task automatic peek(input logic [12:0] a);
	begin
		wr_frame(dev, a, 0, 1'b1);
		repeat (3) @(negedge clk_sys);
		check("read_data", 16'(read_data), 16'(mem[a]));
	end
	endtask : peek

	// poll while busy, then time the programming cycle
	task automatic wait_prog();
	begin
		m.start_cond();
		m.send_byte(dev, ack[0]);
		check("poll ack", 16'(ack[0]), 16'h0);
		m.stop_cond();
		check("busy", 16'(prog_busy), 16'h1);
		for (int i = 0; i < PROG + 20 && prog_busy !== 1'b0; i++)
			@(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
		check("busy length", 16'(last_len), 16'(PROG));
	end
	endtask : wait_prog

	task automatic final_report();
	begin
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask : final_report

	// main sequence
	initial
	begin
		cyc       = $urandom(32'h8090d138);
		cyc       = 0;
		bad_count = 0;
		checked   = 0;
		rstn      = 1'b0;
		wp        = 1'b0;
		strap     = 3'($urandom);
		dev       = {4'ha, strap, 1'b0};
		repeat (3) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (5) @(negedge clk_sys);
		// a byte with no start before it is ignored
		m.send_byte(dev, ack[0]);
		check("no start", 16'(ack[0]), 16'h0);
		m.stop_cond();
		// wrong code nibble and each wrong strap bit
		wr_frame({4'hb, strap, 1'b0}, 13'h0, 0, 1'b0);
		for (int i = 0; i < 3; i++)
			wr_frame(dev ^ (8'h2 << i), 13'h0, 0, 1'b0);
		// read address is acked, then the device stays silent
		m.start_cond();
		m.send_byte(dev | 8'h01, ack[0]);
		check("read ack", 16'(ack[0]), 16'h1);
		m.send_byte(8'hff, ack[0]);
		check("read silent", 16'(ack[0]), 16'h0);
		m.stop_cond();
		// byte write
		a1 = 13'($urandom);
		wr_frame(dev, a1, 1, 1'b1);
		wait_prog();
		peek(a1);
		// page write of 34 bytes from slot 30: wraps and overwrites
		a2 = {8'($urandom), 5'h1e};
		wr_frame(dev, a2, 34, 1'b1);
		wait_prog();
		for (int k = 0; k < 4; k++)
			peek({a2[12:5], 5'(k < 2 ? k : k + 28)});
		// protected write is acked but never programmed
		wp = 1'b1;
		wr_frame(dev, a1, 1, 1'b1);
		repeat (30) @(negedge clk_sys);
		check("wp busy", 16'(prog_busy), 16'h0);
		wp = 1'b0;
		peek(a1);
		final_report();
	end
endmodule : tb
`default_nettype wire
